//--- design/pcsa_core.sv
// program counter, stack and data addressing core with wishbone view
// Notes on behaviour
// - pc steps by one each instruction cycle unless the instruction loads it.
// - direct jump takes pc bits 8..0 from its address field.
// - pc low byte register reads and writes pc bits 7..0.
// - jump, call and pc low byte write copy the two page select bits into pc bits 10..9.
// - call or pc low byte write loads bits 7..0 and clears bit 8.
// - reset sets all pc bits; next step rolls over to 00h.
// - reset clears page select bits so jumps go to page 0.
// - return stack is four levels of 12 bits.
// - call shifts levels down and stores pc plus one in level 1.
// - beyond four calls only the four newest returns are kept, silently.
// - return with literal pops level 1 into pc, levels move up.
// - over-popping refills from the deepest held value, never cleared.
// - return with literal loads the accumulator with its literal.
// - no overflow or underflow flag exists.
// - indirect access port reaches the register the pointer names.
// - indirect read with pointer zero returns 00h.
// - indirect write with pointer zero stores nothing.
// - indirect pointer is eight bits and covers all data memory.
// - bank select only written by load bank literal, not mapped.
// - indirect addresses ignore bank select.
// - pc is eleven bits, addressing 2K words.
// - fetches above 05FFh fold back into implemented space.
// - page codes 00, 01, 10; 11 is reserved.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module pcsa_core
    import pcsa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // execute stage
    input wire logic instr_adv_i,
    input wire logic op_jump_i,
    input wire logic [pcsa_pkg::JUMP_W-1:0] jump_addr_i,
    input wire logic op_call_i,
    input wire logic [pcsa_pkg::DATA_W-1:0] call_addr_i,
    input wire logic op_ret_i,
    input wire logic [pcsa_pkg::DATA_W-1:0] literal_i,
    input wire logic op_bank_i,
    input wire logic [pcsa_pkg::BANK_W-1:0] bank_lit_i,
    input wire logic page_wr_i,
    input wire logic [pcsa_pkg::PAGE_W-1:0] page_data_i,
    input wire logic [pcsa_pkg::FILE_W-1:0] file_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [pcsa_pkg::DATA_W-1:0] wr_data_i,
    output logic [pcsa_pkg::DATA_W-1:0] rd_data_o,
    output logic [pcsa_pkg::PC_W-1:0] pc_o,
    output logic [pcsa_pkg::PC_W-1:0] fetch_addr_o,
    output logic [pcsa_pkg::PAGE_W-1:0] page_o,
    output logic acc_load_o,
    output logic [pcsa_pkg::DATA_W-1:0] acc_data_o,
    // data memory
    output logic [pcsa_pkg::DATA_W-1:0] mem_raddr_o,
    input wire logic [pcsa_pkg::DATA_W-1:0] mem_rdata_i,
    output logic mem_we_o,
    output logic [pcsa_pkg::DATA_W-1:0] mem_waddr_o,
    output logic [pcsa_pkg::DATA_W-1:0] mem_wdata_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pcsa_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [PC_W-1:0] pc_inc;
    logic [PAGE_W-1:0] page_r;
    logic [STK_W-1:0] stk_top;
    logic [DATA_W-1:0] daddr;
    logic [DATA_W-1:0] ptr;
    logic [BANK_W-1:0] bank;
    logic indirect;
    logic null_acc;
    logic pcl_wr;
    logic ptr_wr;
    logic plain_wr;
    logic do_ret;
    logic do_call;
    logic do_jump;
    logic ack_r;
    logic wb_req;
    logic wb_wr_ptr;
    logic [31:0] wb_rd;

    // branch decode, return has priority, then call, then jump
    always_comb
    begin
        do_ret = instr_adv_i && op_ret_i;
        do_call = instr_adv_i && op_call_i && !op_ret_i;
        do_jump = instr_adv_i && op_jump_i && !op_ret_i && !op_call_i;
        pcl_wr = instr_adv_i && mem_wr_i && !null_acc && (daddr == ADDR_PCL);
        ptr_wr = instr_adv_i && mem_wr_i && !null_acc && (daddr == ADDR_PTR);
        plain_wr = instr_adv_i && mem_wr_i && !null_acc && !pcl_wr && !ptr_wr;
    end

    assign pc_inc = pc_r + 11'h001;

    always_comb
    begin
        pc_nxt = pc_inc;
        if (do_ret)
            pc_nxt = stk_top[PC_W-1:0];
        else if (do_call)
            pc_nxt = {page_r, 1'b0, call_addr_i};
        else if (do_jump)
            pc_nxt = {page_r, jump_addr_i};
        else if (pcl_wr)
            pc_nxt = {page_r, 1'b0, wr_data_i};
    end

    // eleven bit counter wraps 7ffh to 000h
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pc_r <= PC_RST;
        else if (instr_adv_i)
            pc_r <= pc_nxt;
    end

    // page select bits, reserved code refused
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            page_r <= PAGE_RST;
        else if (instr_adv_i && page_wr_i && page_data_i != PAGE_RESERVED)
            page_r <= page_data_i;
    end

    // upper unimplemented block folds onto last page
    always_comb
    begin
        if (pc_r >= PC_IMPL_TOP)
            fetch_addr_o = pc_r - PC_FOLD_OFS;
        else
            fetch_addr_o = pc_r;
    end

    assign pc_o = pc_r;
    assign page_o = page_r;

    // no overflow or underflow flag kept
    pcsa_stack #(
        .DEPTH(STK_DEPTH),
        .W(STK_W)
    ) u_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(do_call),
        .pop_i(do_ret),
        .push_data_i({1'b0, pc_inc}),
        .top_o(stk_top)
    );

    pcsa_addr u_addr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bank_wr_i(instr_adv_i && op_bank_i),
        .bank_lit_i(bank_lit_i),
        .dp_ptr_wr_i(ptr_wr),
        .dp_ptr_data_i(wr_data_i),
        .wb_ptr_wr_i(wb_wr_ptr),
        .wb_ptr_data_i(wb_dat_i[DATA_W-1:0]),
        .file_i(file_i),
        .bank_o(bank),
        .ptr_o(ptr),
        .addr_o(daddr),
        .indirect_o(indirect),
        .null_o(null_acc)
    );

    // accumulator load from return with literal
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_load_o <= 1'b0;
            acc_data_o <= NULL_DATA;
        end
        else
        begin
            acc_load_o <= do_ret;
            if (do_ret)
                acc_data_o <= literal_i;
        end
    end

    // operand read path
    assign mem_raddr_o = daddr;

    always_comb
    begin
        if (null_acc)
            rd_data_o = NULL_DATA;
        else if (daddr == ADDR_PCL)
            rd_data_o = pc_r[DATA_W-1:0];
        else if (daddr == ADDR_PTR)
            rd_data_o = ptr;
        else
            rd_data_o = mem_rdata_i;
    end

    // destination write to data memory
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_we_o <= 1'b0;
            mem_waddr_o <= NULL_DATA;
            mem_wdata_o <= NULL_DATA;
        end
        else
        begin
            mem_we_o <= plain_wr;
            if (plain_wr)
            begin
                mem_waddr_o <= daddr;
                mem_wdata_o <= wr_data_i;
            end
        end
    end

    // wishbone slave, one wait state
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr_ptr = wb_req && ack_r && wb_we_i && wb_sel_i[0] && (wb_adr_i == WB_OFS_PTR);

    always_comb
    begin
        case (wb_adr_i)
            WB_OFS_PTR: wb_rd = {24'h000000, ptr};
            WB_OFS_PC: wb_rd = {19'h00000, page_r, pc_r[PC_W-1:PC_B8], pc_r[DATA_W-1:0]};
            WB_OFS_CTX: wb_rd = {27'h0000000, indirect, null_acc, bank};
            default: wb_rd = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ack_r <= wb_req && !ack_r;
            if (wb_req && !ack_r)
                wb_dat_o <= wb_rd;
        end
    end

    assign wb_ack_o = ack_r;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_call;
        instr_adv_i && op_call_i && !op_ret_i;
    endsequence

    sequence s_ret;
        instr_adv_i && op_ret_i;
    endsequence

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !ack_r;
    endsequence

    a_pc_step: assert property (
        instr_adv_i && !op_ret_i && !op_call_i && !op_jump_i && !pcl_wr |=> pc_r == $past(pc_inc))
        else $error("pc did not step by one");

    a_jump_target: assert property (
        instr_adv_i && op_jump_i && !op_call_i && !op_ret_i |=> pc_r == {$past(page_r), $past(jump_addr_i)})
        else $error("jump target wrong");

    a_bit8_cleared: assert property (
        instr_adv_i && (op_call_i || (pcl_wr && !op_jump_i)) && !op_ret_i |=> !pc_r[PC_B8])
        else $error("pc bit 8 not cleared");

    a_reset_pc: assert property (
        $past(rst_i) |-> pc_r == PC_RST && page_r == PAGE_RST)
        else $error("reset state wrong");

    a_call_return: assert property (
        s_call ##1 !instr_adv_i ##1 (s_ret and !op_call_i) |=> pc_r == $past(pc_inc, 3))
        else $error("return did not restore call address");

    a_ret_literal: assert property (
        s_ret |=> acc_load_o && acc_data_o == $past(literal_i))
        else $error("literal not loaded");

    a_null_read: assert property (
        indirect && ptr == PTR_RST |-> rd_data_o == NULL_DATA)
        else $error("null indirect read not zero");

    a_null_write: assert property (
        instr_adv_i && mem_wr_i && null_acc |=> !mem_we_o)
        else $error("null indirect write stored");

    a_bank_ignored: assert property (
        indirect |-> mem_raddr_o == ptr)
        else $error("bank used on indirect access");

    a_wb_answer: assert property (
        s_wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack timing wrong");

    a_page_call: assert property (
        s_call |=> pc_r[PC_W-1:PC_W-PAGE_W] == $past(page_r))
        else $error("call page bits wrong");

    a_page_reserved: assert property (
        instr_adv_i && page_wr_i && page_data_i == PAGE_RESERVED |=> page_r == $past(page_r))
        else $error("reserved page code taken");

    a_pcl_load: assert property (
        pcl_wr && !op_ret_i && !op_call_i && !op_jump_i |=> pc_r[DATA_W-1:0] == $past(wr_data_i))
        else $error("pc low byte write lost");

    a_fetch_fold: assert property (
        fetch_addr_o < PC_IMPL_TOP && fetch_addr_o[PC_B8:0] == pc_r[PC_B8:0])
        else $error("fetch address outside implemented space");

    a_bank_load: assert property (
        instr_adv_i && op_bank_i |=> bank == $past(bank_lit_i))
        else $error("bank select not loaded");

    a_ind_write: assert property (
        instr_adv_i && mem_wr_i && indirect && ptr != PTR_RST && ptr != ADDR_PCL && ptr != ADDR_PTR
            |=> mem_we_o && mem_waddr_o == $past(ptr))
        else $error("indirect write went astray");

    a_ptr_bus_write: assert property (
        wb_ack_o && wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_OFS_PTR && !ptr_wr
            |=> ptr == $past(wb_dat_i[DATA_W-1:0]))
        else $error("pointer bus write lost");
endmodule // pcsa_core

//--- design/pcsa_pkg.sv
// shared constants for program sequencing and data addressing
package pcsa_pkg;
    localparam int PC_W = 11;
    localparam int STK_DEPTH = 4;
    localparam int STK_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 3;
    localparam int FILE_W = 5;
    localparam int PAGE_W = 2;
    localparam int JUMP_W = 9;
    localparam int WB_AW = 4;
    // program counter
    localparam logic [10:0] PC_RST = 11'h7ff;
    localparam logic [10:0] PC_IMPL_TOP = 11'h600;
    localparam logic [10:0] PC_FOLD_OFS = 11'h200;
    localparam int PC_B8 = 8;
    localparam logic [1:0] PAGE_RST = 2'h0;
    localparam logic [1:0] PAGE_RESERVED = 2'h3;
    // data addressing
    localparam logic [2:0] BANK_RST = 3'h0;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [4:0] FILE_INDIRECT = 5'h00;
    localparam logic [7:0] ADDR_PCL = 8'h02;
    localparam logic [7:0] ADDR_PTR = 8'h04;
    localparam logic [7:0] NULL_DATA = 8'h00;
    localparam logic [11:0] STK_RST = 12'h000;
    // wishbone byte offsets
    localparam logic [3:0] WB_OFS_PTR = 4'h0;
    localparam logic [3:0] WB_OFS_PC = 4'h4;
    localparam logic [3:0] WB_OFS_CTX = 4'h8;
endpackage

//--- design/pcsa_stack.sv
// return-address stack, shift on push and pop
`timescale 1ns/1ps
module pcsa_stack
    import pcsa_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH,
    parameter int W = STK_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [W-1:0] push_data_i,
    output logic [W-1:0] top_o
);
    logic [W-1:0] lvl_r [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
                lvl_r[i] <= W'(STK_RST);
        end
        else if (push_i)
        begin
            lvl_r[0] <= push_data_i;
            for (int i = 1; i < DEPTH; i++)
                lvl_r[i] <= lvl_r[i-1];
        end
        else if (pop_i)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                lvl_r[i] <= lvl_r[i+1];
            lvl_r[DEPTH-1] <= lvl_r[DEPTH-1];
        end
    end

    assign top_o = lvl_r[0];
endmodule // pcsa_stack

//--- design/pcsa_addr.sv
// bank select, indirect pointer and data address forming
`timescale 1ns/1ps
module pcsa_addr
    import pcsa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bank_wr_i,
    input wire logic [BANK_W-1:0] bank_lit_i,
    input wire logic dp_ptr_wr_i,
    input wire logic [DATA_W-1:0] dp_ptr_data_i,
    input wire logic wb_ptr_wr_i,
    input wire logic [DATA_W-1:0] wb_ptr_data_i,
    input wire logic [FILE_W-1:0] file_i,
    output logic [BANK_W-1:0] bank_o,
    output logic [DATA_W-1:0] ptr_o,
    output logic [DATA_W-1:0] addr_o,
    output logic indirect_o,
    output logic null_o
);
    logic [BANK_W-1:0] bank_r;
    logic [DATA_W-1:0] ptr_r;

    // only the load-bank-literal op reaches this register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bank_r <= BANK_RST;
        else if (bank_wr_i)
            bank_r <= bank_lit_i;
    end

    // data path write wins over bus write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ptr_r <= PTR_RST;
        else if (dp_ptr_wr_i)
            ptr_r <= dp_ptr_data_i;
        else if (wb_ptr_wr_i)
            ptr_r <= wb_ptr_data_i;
    end

    always_comb
    begin
        indirect_o = (file_i == FILE_INDIRECT);
        if (indirect_o)
            addr_o = ptr_r;
        else
            addr_o = {bank_r, file_i};
        null_o = indirect_o && (ptr_r == PTR_RST);
    end

    assign bank_o = bank_r;
    assign ptr_o = ptr_r;
endmodule // pcsa_addr

//--- bench/pcsa_mem_model.sv
// data memory model on the far side of the core
`timescale 1ns/1ps
module pcsa_mem_model
(
    input wire logic clk_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem_r [256];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_r[i] = ~i[7:0];
    end
    assign rdata_o = mem_r[raddr_i];
    always @(posedge clk_i)
    begin
        if (we_i)
            mem_r[waddr_i] <= wdata_i;
    end
endmodule // pcsa_mem_model

//--- bench/pc_stack_indirect_addressing_test.sv
// self-checking bench for the pc, stack and data addressing core
`timescale 1ns/1ps
module pc_stack_indirect_addressing_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic adv = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic wwe = 1'b0;
    logic [5:0] ops = 6'h0;
    logic [8:0] a = 9'h0;
    logic [7:0] v = 8'h0;
    logic [4:0] fil = 5'h0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [10:0] pc_o, fetch_addr_o;
    logic [1:0] page_o;
    logic [7:0] rd_data_o, acc_data_o, mem_raddr_o, mrd, mem_waddr_o, mem_wdata_o;
    logic acc_load_o, mem_we_o, wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [10:0] pcm = 11'h7ff;
    logic [1:0] pm = 2'h0;
    logic [2:0] bm = 3'h0;
    logic [7:0] ptrm = 8'h0;
    logic [47:0] stk = 48'h0;
    logic [31:0] exp_wb[$], exp_acc[$], exp_mw[$];
    int checked = 0;
    int fails = 0;
    int cycles = 0;

    pcsa_core u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .instr_adv_i(adv), .op_jump_i(ops[0]), .jump_addr_i(a),
        .op_call_i(ops[1]), .call_addr_i(a[7:0]), .op_ret_i(ops[2]), .literal_i(v),
        .op_bank_i(ops[3]), .bank_lit_i(a[2:0]), .page_wr_i(ops[4]), .page_data_i(a[1:0]),
        .file_i(fil), .mem_rd_i(1'b1), .mem_wr_i(ops[5]), .wr_data_i(v), .rd_data_o(rd_data_o),
        .pc_o(pc_o), .fetch_addr_o(fetch_addr_o), .page_o(page_o), .acc_load_o(acc_load_o),
        .acc_data_o(acc_data_o), .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mrd), .mem_we_o(mem_we_o),
        .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));
    pcsa_mem_model u_mem (.clk_i(clk_i), .raddr_i(mem_raddr_o), .rdata_o(mrd), .we_i(mem_we_o),
        .waddr_i(mem_waddr_o), .wdata_i(mem_wdata_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one compare task per kind of result
    task automatic chk_pc(input logic [31:0] got, input logic [31:0] exp, input string what);
        chk(got, exp, what);
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
        chk(got, exp, what);
    endtask

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp, "bus");
    endtask

    task automatic chk_acc(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp, "acc");
    endtask

    task automatic chk_mem(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp, "mem");
    endtask

    task automatic summarize();
        chk(exp_wb.size() + exp_acc.size() + exp_mw.size(), 32'h0, "left");
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one classic wishbone cycle, read data noted for the watcher
    task automatic wb(input logic we, input logic [3:0] ad, input logic [31:0] d, input logic [31:0] e);
        if (!we)
            exp_wb.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= we;
        adr <= ad;
        sel <= 4'hf;
        dat <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask

    // one instruction: update the reference, drive, then compare pc and page
    task automatic ins(input int op, input logic [8:0] an, input logic [7:0] vn);
        logic [10:0] nxt;
        logic [7:0] ea;
        nxt = pcm + 11'h1;
        ea = (an[4:0] == 5'h00) ? ptrm : {bm, an[4:0]};
        case (op)
            1: nxt = {pm, an};
            2:
            begin
                stk = {stk[35:0], 1'b0, pcm + 11'h1};
                nxt = {pm, 1'b0, an[7:0]};
            end
            3:
            begin
                nxt = stk[10:0];
                stk = {stk[47:36], stk[47:12]};
                exp_acc.push_back({24'h0, vn});
            end
            4: bm = an[2:0];
            5: pm = (an[1:0] == 2'h3) ? pm : an[1:0];
            6:
            begin
                if (ea == 8'h02)
                    nxt = {pm, 1'b0, vn};
                else if (ea == 8'h04)
                    ptrm = vn;
                else if (ea != 8'h00)
                    exp_mw.push_back({16'h0, ea, vn});
            end
            default: ;
        endcase
        pcm = nxt;
        adv <= 1'b1;
        ops <= (op == 0) ? 6'h0 : 6'h1 << (op - 1);
        a <= an;
        v <= vn;
        if (op == 6)
            fil <= an[4:0];
        @(posedge clk_i);
        adv <= 1'b0;
        ops <= 6'h0;
        @(posedge clk_i);
        chk_pc({21'h0, pc_o}, {21'h0, pcm}, "pc");
        chk_pc({30'h0, page_o}, {30'h0, pm}, "page");
    endtask

    task automatic look(input logic [4:0] f, input logic [7:0] ra, input logic [7:0] rd);
        fil <= f;
        @(posedge clk_i);
        chk_rd({24'h0, mem_raddr_o}, {24'h0, ra}, "raddr");
        chk_rd({24'h0, rd_data_o}, {24'h0, rd}, "rdata");
    endtask

    // watcher: each result takes the oldest note
    always @(posedge clk_i)
    begin
        cycles++;
        if (wb_ack_o === 1'b1 && wwe === 1'b0)
            chk_bus(wb_dat_o, exp_wb.size() ? exp_wb.pop_front() : 'x);
        if (acc_load_o === 1'b1)
            chk_acc({24'h0, acc_data_o}, exp_acc.size() ? exp_acc.pop_front() : 'x);
        if (mem_we_o === 1'b1)
            chk_mem({16'h0, mem_waddr_o, mem_wdata_o}, exp_mw.size() ? exp_mw.pop_front() : 'x);
        if (cycles == 5000)
        begin
            fails++;
            summarize();
        end
    end

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        logic [7:0] r;
        r = 8'($urandom(32'h4fcf));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_pc({21'h0, pc_o}, 32'h7ff, "rst pc");
        chk_pc({21'h0, fetch_addr_o}, 32'h5ff, "fold");
        ins(0, 9'h0, 8'h0);
        wb(1'b0, 4'h4, 32'h0, {19'h0, pm, pcm});
        $display("test reset done");
        ins(5, 9'h2, 8'h0);
        ins(1, 9'h1ab, 8'h0);
        ins(0, 9'h0, 8'h0);
        ins(5, 9'h3, 8'h0);
        ins(6, 9'h2, r);
        look(5'h02, 8'h02, pcm[7:0]);
        $display("test branch done");
        repeat (5) ins(2, 9'($urandom), 8'h0);
        repeat (6) ins(3, 9'h0, 8'($urandom));
        $display("test stack done");
        wb(1'b1, 4'h0, 32'h9c, 32'h0);
        ptrm = 8'h9c;
        wb(1'b0, 4'h0, 32'h0, 32'h9c);
        ins(4, 9'h5, 8'h0);
        ins(6, 9'h0, r);
        look(5'h00, 8'h9c, r);
        look(5'h13, 8'hb3, 8'h4c);
        wb(1'b1, 4'h0, 32'h0, 32'h0);
        ptrm = 8'h0;
        ins(6, 9'h0, 8'h77);
        look(5'h00, 8'h00, 8'h00);
        wb(1'b0, 4'h8, 32'h0, 32'h1d);
        wb(1'b1, 4'h8, 32'h0, 32'h0);
        wb(1'b0, 4'h8, 32'h0, 32'h1d);
        wb(1'b1, 4'h4, 32'h7ff, 32'h0);
        wb(1'b0, 4'h4, 32'h0, {19'h0, pm, pcm});
        wb(1'b0, 4'hc, 32'h0, 32'h0);
        $display("test data done");
        summarize();
    end
endmodule // pc_stack_indirect_addressing_test
